// [hdl/dsrmw_defs.svh]
// Constants for the decorated store read-modify-write bridge.
// Assumes 32-bit AHB address and data paths.
`ifndef DSRMW_DEFS_SVH
`define DSRMW_DEFS_SVH
`define DSRMW_DEC_BASE_LO  32'h4400_0000
`define DSRMW_DEC_BASE_HI  32'h5FFF_FFFF
`define DSRMW_LOGIC_MASK   32'hE00F_FFFF
`define DSRMW_FIELD_MASK   32'hE007_FFFF
`define DSRMW_OP_HI        28
`define DSRMW_OP_LO        26
`define DSRMW_POS_HI       27
`define DSRMW_POS_LO       23
`define DSRMW_WID_HI       22
`define DSRMW_WID_LO       19
`define DSRMW_SIZE_BYTE    3'h0
`define DSRMW_SIZE_HALF    3'h1
`define DSRMW_SIZE_WORD    3'h2
`define DSRMW_HTRANS_IDLE  2'h0
`define DSRMW_HTRANS_NSEQ  2'h2
`endif

// [hdl/dsrmw_pkg.sv]
// Types for the decorated store read-modify-write bridge.
// Assumes dsrmw_defs.svh supplies the numeric constants.
package dsrmw_pkg;
  typedef enum logic [2:0] {
    DSRMW_OP_NONE = 3'b000,
    DSRMW_OP_AND  = 3'b001,
    DSRMW_OP_OR   = 3'b010,
    DSRMW_OP_XOR  = 3'b011,
    DSRMW_OP_BFI  = 3'b100
  } dsrmw_op_t;
  typedef enum logic [1:0] {
    DSRMW_ST_PASS  = 2'b00,
    DSRMW_ST_MOD   = 2'b01,
    DSRMW_ST_WRITE = 2'b10
  } dsrmw_state_t;
endpackage : dsrmw_pkg

// [hdl/dsrmw_modify.sv]
// Combines read data with write data for one decorated store.
// Assumes read data and write data are lane-replicated by size.
`timescale 1ns/1ps
`include "dsrmw_defs.svh"
module dsrmw_modify #(
  parameter int DW = 32
) (
  // Operation
  input  wire dsrmw_pkg::dsrmw_op_t op,
  input  wire logic [4:0]          pos,
  input  wire logic [3:0]          wid,
  input  wire logic [2:0]          size,
  // Data
  input  wire logic [DW-1:0]       rdata,
  input  wire logic [DW-1:0]       wdata,
  output logic      [DW-1:0]       result
);
  logic [DW-1:0] field_m;
  logic [DW-1:0] cont_m;
  logic [DW-1:0] ins_m;

  // Container mask limits the field to the access size
  always_comb begin
    case (size)
      `DSRMW_SIZE_BYTE: cont_m = DW'(32'h0000_00FF);
      `DSRMW_SIZE_HALF: cont_m = DW'(32'h0000_FFFF);
      default:          cont_m = {DW{1'b1}};
    endcase
  end

  // Mask of w+1 ones at b; bits past the container are dropped
  always_comb begin
    field_m = ((DW'(2) << wid) - DW'(1)) << pos;
    ins_m   = field_m & cont_m;
  end

  always_comb begin
    case (op)
      dsrmw_pkg::DSRMW_OP_AND: result = rdata & wdata;
      dsrmw_pkg::DSRMW_OP_OR:  result = rdata | wdata;
      dsrmw_pkg::DSRMW_OP_XOR: result = rdata ^ wdata;
      dsrmw_pkg::DSRMW_OP_BFI:
        result = (rdata & ~ins_m) | (wdata & ins_m);
      default:                 result = wdata;
    endcase
  end
endmodule : dsrmw_modify

// [hdl/dsrmw_bridge.sv]
// Decorated store bridge between a crossbar AHB slave port and the
// peripheral bridge. Turns decorated stores into atomic RMW.
// Assumes one AHB master upstream and an AHB slave downstream,
// both on sys_clk; the master replicates narrow write data itself.
//
// Contract
// - Code 010 ORs write data into target.
// - Code 011 XORs write data into target.
// - Read and write run back to back, indivisible.
// - Operand size follows the write transfer size.
// - Logical address masked with E00FFFFF for both.
// - Bits 25 to 20 ignored for OR/XOR.
// - Cycle x: undecorated read out, capture attributes.
// - Cycle x+1: captured address reissued as write.
// - Data phase one: modify and register result.
// - Cycle x+2: registered data driven as write data.
// - Field insert of width w+1 at b.
// - Code 001 ANDs write data into target.
// - Upstream ready held low during modify phase.
// - Downstream wait states passed straight upstream.
// - Insert: bit 28, b at 27:23, w at 22:19.
`timescale 1ns/1ps
`include "dsrmw_defs.svh"
module dsrmw_bridge #(
  parameter int AW = 32,
  parameter int DW = 32
) (
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rst_b,
  // Upstream AHB slave port
  input  wire logic          up_hsel,
  input  wire logic [AW-1:0] up_haddr,
  input  wire logic [1:0]    up_htrans,
  input  wire logic          up_hwrite,
  input  wire logic [2:0]    up_hsize,
  input  wire logic [3:0]    up_hprot,
  input  wire logic [DW-1:0] up_hwdata,
  output logic      [DW-1:0] up_hrdata,
  output logic               upstream_ready,
  output logic               up_hresp,
  // Downstream AHB master port to the peripheral bridge
  output logic               dn_hsel,
  output logic      [AW-1:0] dn_haddr,
  output logic      [1:0]    dn_htrans,
  output logic               dn_hwrite,
  output logic      [2:0]    dn_hsize,
  output logic      [3:0]    dn_hprot,
  output logic      [DW-1:0] dn_hwdata,
  input  wire logic [DW-1:0] dn_hrdata,
  input  wire logic          downstream_ready,
  input  wire logic          dn_hresp
);
  logic                    rst_s1_q;
  logic                    rst_n_q;
  dsrmw_pkg::dsrmw_state_t st_q;
  dsrmw_pkg::dsrmw_op_t    dec_op;
  dsrmw_pkg::dsrmw_op_t    op_q;
  logic                    in_region;
  logic                    dec_start;
  logic [AW-1:0]           real_addr;
  logic [AW-1:0]           addr_q;
  logic [2:0]              size_q;
  logic [3:0]              prot_q;
  logic [4:0]              pos_q;
  logic [3:0]              wid_q;
  logic [DW-1:0]           mod_data;
  logic [DW-1:0]           wdata_q;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // Decode of the decoration; only bits 28:26 matter for logic ops
  always_comb begin
    in_region = (up_haddr >= `DSRMW_DEC_BASE_LO) &&
                (up_haddr <= `DSRMW_DEC_BASE_HI);
    if (up_haddr[`DSRMW_OP_HI]) begin
      dec_op    = dsrmw_pkg::DSRMW_OP_BFI;
      real_addr = up_haddr & `DSRMW_FIELD_MASK;
    end else begin
      case (up_haddr[`DSRMW_OP_HI:`DSRMW_OP_LO])
        3'b001:  dec_op = dsrmw_pkg::DSRMW_OP_AND;
        3'b010:  dec_op = dsrmw_pkg::DSRMW_OP_OR;
        3'b011:  dec_op = dsrmw_pkg::DSRMW_OP_XOR;
        default: dec_op = dsrmw_pkg::DSRMW_OP_NONE;
      endcase
      real_addr = up_haddr & `DSRMW_LOGIC_MASK;
    end
  end

  // Decorated loads and unknown codes fall through undecorated
  assign dec_start = up_hsel && up_htrans[1] && up_hwrite &&
                     in_region &&
                     (dec_op != dsrmw_pkg::DSRMW_OP_NONE) &&
                     upstream_ready &&
                     (st_q != dsrmw_pkg::DSRMW_ST_MOD);

  // Sequencer: PASS -> MOD -> WRITE -> PASS, or WRITE -> MOD
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= dsrmw_pkg::DSRMW_ST_PASS;
    end else begin
      case (st_q)
        dsrmw_pkg::DSRMW_ST_PASS: begin
          if (dec_start && downstream_ready) begin
            st_q <= dsrmw_pkg::DSRMW_ST_MOD;
          end
        end
        dsrmw_pkg::DSRMW_ST_MOD: begin
          if (downstream_ready) begin
            st_q <= dsrmw_pkg::DSRMW_ST_WRITE;
          end
        end
        dsrmw_pkg::DSRMW_ST_WRITE: begin
          // Next address phase overlaps this write data phase
          if (dec_start && downstream_ready) begin
            st_q <= dsrmw_pkg::DSRMW_ST_MOD;
          end else if (downstream_ready) begin
            st_q <= dsrmw_pkg::DSRMW_ST_PASS;
          end
        end
        default: st_q <= dsrmw_pkg::DSRMW_ST_PASS;
      endcase
    end
  end

  // Capture address and attributes in the first address phase
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      addr_q <= '0;
      size_q <= `DSRMW_SIZE_BYTE;
      prot_q <= 4'h0;
      op_q   <= dsrmw_pkg::DSRMW_OP_NONE;
      pos_q  <= 5'h0;
      wid_q  <= 4'h0;
    end else if (dec_start && downstream_ready) begin
      addr_q <= real_addr;
      size_q <= up_hsize;
      prot_q <= up_hprot;
      op_q   <= dec_op;
      pos_q  <= up_haddr[`DSRMW_POS_HI:`DSRMW_POS_LO];
      wid_q  <= up_haddr[`DSRMW_WID_HI:`DSRMW_WID_LO];
    end
  end

  dsrmw_modify #(
    .DW (DW)
  ) u_modify (
    .op     (op_q),
    .pos    (pos_q),
    .wid    (wid_q),
    .size   (size_q),
    .rdata  (dn_hrdata),
    .wdata  (up_hwdata),
    .result (mod_data)
  );

  // Modified data captured at the end of the first data phase
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wdata_q <= '0;
    end else if (st_q == dsrmw_pkg::DSRMW_ST_MOD && downstream_ready) begin
      wdata_q <= mod_data;
    end
  end

  // Downstream address phase; pass-through is combinational
  always_comb begin
    dn_hsel   = up_hsel;
    dn_haddr  = up_haddr;
    dn_htrans = up_htrans;
    dn_hwrite = up_hwrite;
    dn_hsize  = up_hsize;
    dn_hprot  = up_hprot;
    case (st_q)
      dsrmw_pkg::DSRMW_ST_MOD: begin
        dn_hsel   = 1'b1;
        dn_haddr  = addr_q;
        dn_htrans = `DSRMW_HTRANS_NSEQ;
        dn_hwrite = 1'b1;
        dn_hsize  = size_q;
        dn_hprot  = prot_q;
      end
      default: begin
        // Also x+2: master's next address phase must not be dropped
        if (dec_start) begin
          dn_haddr  = real_addr;
          dn_hwrite = 1'b0;
        end
      end
    endcase
  end

  // Write data: registered result in x+2, master data otherwise
  always_comb begin
    if (st_q == dsrmw_pkg::DSRMW_ST_WRITE) begin
      dn_hwdata = wdata_q;
    end else begin
      dn_hwdata = up_hwdata;
    end
  end

  // Ready: stall in modify phase, else wait states pass through
  always_comb begin
    if (st_q == dsrmw_pkg::DSRMW_ST_MOD) begin
      upstream_ready = 1'b0;
    end else begin
      upstream_ready = downstream_ready;
    end
  end

  assign up_hrdata = dn_hrdata;
  assign up_hresp  = dn_hresp;

  // Checks
  sequence s_rmw_start;
    dec_start && downstream_ready;
  endsequence

  sequence s_mod_done;
    (st_q == dsrmw_pkg::DSRMW_ST_MOD) && downstream_ready;
  endsequence

  a_stall_in_mod: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    s_rmw_start |=> !upstream_ready)
    else $error("upstream ready not low in modify phase");

  a_write_follows: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    s_rmw_start |=> dn_hwrite && dn_htrans == `DSRMW_HTRANS_NSEQ &&
                    dn_haddr == $past(real_addr))
    else $error("write address phase not reissued");

  a_read_first: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    s_rmw_start |-> !dn_hwrite && dn_haddr == real_addr)
    else $error("decorated store not turned into read");

  a_addr_masked: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    s_rmw_start and !up_haddr[28] |->
      (dn_haddr & ~`DSRMW_LOGIC_MASK) == 32'h0000_0000)
    else $error("logical address not masked");

  a_data_written: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    s_mod_done |=> dn_hwdata == $past(mod_data))
    else $error("registered data not driven in write phase");

  a_or_result: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    s_mod_done and (op_q == dsrmw_pkg::DSRMW_OP_OR) |=>
      wdata_q == ($past(dn_hrdata) | $past(up_hwdata)))
    else $error("OR result wrong");

  a_xor_result: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    s_mod_done and (op_q == dsrmw_pkg::DSRMW_OP_XOR) |=>
      wdata_q == ($past(dn_hrdata) ^ $past(up_hwdata)))
    else $error("XOR result wrong");

  a_no_intervene: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    st_q == dsrmw_pkg::DSRMW_ST_MOD |->
      dn_hsel && dn_hwrite && dn_haddr == addr_q)
    else $error("access between read and write");

  a_wait_pass: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    st_q != dsrmw_pkg::DSRMW_ST_MOD |-> upstream_ready == downstream_ready)
    else $error("wait state not passed through");

  a_pass_through: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    st_q == dsrmw_pkg::DSRMW_ST_PASS && !in_region |->
      dn_haddr == up_haddr && dn_hwrite == up_hwrite)
    else $error("plain access altered");

  a_attr_reissue: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    s_rmw_start |=> dn_hprot == $past(up_hprot) &&
                    dn_hsize == $past(up_hsize))
    else $error("write attributes not reissued");

  a_next_passes: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    st_q == dsrmw_pkg::DSRMW_ST_WRITE && !dec_start |->
      dn_hsel == up_hsel && dn_haddr == up_haddr &&
      dn_htrans == up_htrans)
    else $error("next address phase not passed on");
endmodule : dsrmw_bridge

// [tb/dsrmw_mem_model.sv]
// Peripheral-side AHB slave memory of 16 words for the bridge bench.
// Assumes one clock; stall adds one wait state to every data phase.
`timescale 1ns/1ps
module dsrmw_mem_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // AHB slave side
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hready,
  output logic             hresp,
  // Bench control
  input  wire logic        stall
);
  logic [31:0] mem [16];
  logic        dp_q;
  logic        wr_q;
  logic        waited_q;
  logic [31:0] a_q;
  logic [2:0]  sz_q;

  function automatic logic [31:0] lanes(input logic [2:0] s,
                                        input logic [1:0] a);
    case (s)
      3'h0: lanes = 32'h0000_00FF << {a, 3'h0};
      3'h1: lanes = 32'h0000_FFFF << {a[1], 4'h0};
      default: lanes = 32'hFFFF_FFFF;
    endcase
  endfunction : lanes

  assign hready = !(stall && dp_q && !waited_q);
  assign hresp  = 1'b0;
  // Outside a read data phase the bus shows a changed value, not stale
  assign hrdata = (dp_q && !wr_q) ? mem[a_q[5:2]] : ~mem[a_q[5:2]];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dp_q     <= 1'b0;
      waited_q <= 1'b0;
    end else begin
      waited_q <= !hready;
      if (hready) begin
        dp_q <= hsel && htrans[1];
        wr_q <= hwrite;
        a_q  <= haddr;
        sz_q <= hsize;
      end
    end
  end

  // Writes land only at undecorated peripheral addresses
  always @(posedge clk) begin
    if (hready && dp_q && wr_q && a_q[31:6] == 26'h100_0000) begin
      mem[a_q[5:2]] <= (mem[a_q[5:2]] & ~lanes(sz_q, a_q[1:0]))
                     | (hwdata & lanes(sz_q, a_q[1:0]));
    end
  end
endmodule : dsrmw_mem_model

// [tb/decorated_store_rmw_tb.sv]
// Self-checking bench for the decorated store bridge.
// Assumes dsrmw_mem_model stands on the downstream port.
`timescale 1ns/1ps
module decorated_store_rmw_tb;
  logic        sys_clk;
  logic        rst_b;
  logic        up_hsel;
  logic        up_hwrite;
  logic        stall;
  logic        upstream_ready;
  logic        downstream_ready;
  logic        dn_hresp;
  logic        up_hresp;
  logic        dn_hsel;
  logic        dn_hwrite;
  logic [1:0]  up_htrans;
  logic [1:0]  dn_htrans;
  logic [2:0]  up_hsize;
  logic [2:0]  dn_hsize;
  logic [31:0] up_haddr;
  logic [31:0] up_hwdata;
  logic [31:0] up_hrdata;
  logic [31:0] dn_haddr;
  logic [31:0] dn_hwdata;
  logic [31:0] dn_hrdata;
  logic [31:0] rd;
  int          bad_count;
  int          cmp_count;
  int          cyc;
  int          n;

  dsrmw_bridge i_dut (
    .sys_clk, .rst_b, .up_hsel, .up_haddr, .up_htrans, .up_hwrite,
    .up_hsize, .up_hprot(4'h3), .up_hwdata, .up_hrdata,
    .upstream_ready, .up_hresp, .dn_hsel, .dn_haddr, .dn_htrans,
    .dn_hwrite, .dn_hsize, .dn_hprot(), .dn_hwdata, .dn_hrdata,
    .downstream_ready, .dn_hresp
  );

  dsrmw_mem_model i_mem (
    .clk(sys_clk), .rst_b, .hsel(dn_hsel), .haddr(dn_haddr),
    .htrans(dn_htrans), .hwrite(dn_hwrite), .hsize(dn_hsize),
    .hwdata(dn_hwdata), .hrdata(dn_hrdata),
    .hready(downstream_ready), .hresp(dn_hresp), .stall
  );

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  // Hang guard well above the fifty-odd cycles the run needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One AHB transfer; n counts data phase cycles up to ready
  task automatic xfer(input logic [31:0] a, input logic [31:0] d,
                      input logic [2:0] s, input logic w);
    @(negedge sys_clk);
    up_hsel   = 1'b1;
    up_htrans = 2'h2;
    up_hwrite = w;
    up_haddr  = a;
    up_hsize  = s;
    @(posedge sys_clk);
    @(negedge sys_clk);
    up_hsel   = 1'b0;
    up_htrans = 2'h0;
    up_hwdata = d;
    n = 1;
    while (upstream_ready !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    rd = up_hrdata;
    @(negedge sys_clk);
  endtask : xfer

  task automatic run_case(input logic [31:0] a, input logic [31:0] d,
                          input logic [31:0] old, input logic [31:0] exp,
                          input logic [2:0] s, input int ncyc);
    i_mem.mem[a[5:2]] = old;
    xfer(a, d, s, 1'b1);
    check(i_mem.mem[a[5:2]], exp);
    if (ncyc > 0) begin
      check(32'(n), 32'(ncyc));
    end
  endtask : run_case

  // Narrow data replicated across lanes, aligned addresses
  task automatic or_test;
    run_case(32'h4BF0_0006, 32'h8181_8181,
             32'h1234_5678, 32'h12B5_5678, 3'h0, 2);
    run_case(32'h4800_000A, 32'hF000_F000,
             32'h0F0F_0F0F, 32'hFF0F_0F0F, 3'h1, 2);
    run_case(32'h4800_000C, 32'h8000_0000,
             32'h0000_0001, 32'h8000_0001, 3'h2, 2);
  endtask : or_test

  task automatic xor_test;
    stall = 1'b1;
    run_case(32'h4C00_0010, 32'h0F0F_0F0F,
             32'hFFFF_0000, 32'hF0F0_0F0F, 3'h2, 4);
    run_case(32'h4000_0020, 32'h5A5A_A5A5,
             32'h0000_0000, 32'h5A5A_A5A5, 3'h2, 2);
    stall = 1'b0;
  endtask : xor_test

  task automatic and_test;
    run_case(32'h4400_0014, 32'hFF00_FF00,
             32'h1234_5678, 32'h1200_5600, 3'h2, 2);
  endtask : and_test

  // Byte field at b=6 spills past the container and is clipped
  task automatic bfi_test;
    run_case(32'h5310_0018, 32'hFFFF_FFFF,
             32'hAAAA_AA00, 32'hAAAA_AAC0, 3'h0, 2);
    run_case(32'h5218_001C, 32'hFFFF_FFFF,
             32'h0000_0000, 32'h0000_00F0, 3'h2, 2);
  endtask : bfi_test

  // Plain read held behind a store is taken in x+2 of that store
  task automatic b2b_test;
    i_mem.mem[9] = 32'h0000_00F0;
    @(negedge sys_clk);
    up_hsel   = 1'b1;
    up_htrans = 2'h2;
    up_hwrite = 1'b1;
    up_haddr  = 32'h4800_0024;
    up_hsize  = 3'h2;
    @(negedge sys_clk);
    up_hwrite = 1'b0;
    up_haddr  = 32'h4000_0024;
    up_hwdata = 32'h0000_000F;
    n = 1;
    while (upstream_ready !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    up_hsel   = 1'b0;
    up_htrans = 2'h0;
    check(32'(n), 32'h0000_0002);
    check(up_hrdata, 32'h0000_00FF);
    check(32'(up_hresp), 32'h0000_0000);
    @(negedge sys_clk);
    check(i_mem.mem[9], 32'h0000_00FF);
  endtask : b2b_test

  task automatic plain_test;
    run_case(32'h4000_0024, 32'h1357_9BDF,
             32'h0000_0000, 32'h1357_9BDF, 3'h2, 1);
    xfer(32'h4000_0024, 32'h0000_0000, 3'h2, 1'b0);
    check(rd, 32'h1357_9BDF);
    check(32'(n), 32'h0000_0001);
  endtask : plain_test

  initial begin
    rst_b     = 1'b0;
    stall     = 1'b0;
    up_hsel   = 1'b0;
    up_htrans = 2'h0;
    up_hwrite = 1'b0;
    up_haddr  = 32'h0000_0000;
    up_hsize  = 3'h0;
    up_hwdata = 32'h0000_0000;
    repeat (3) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (3) @(negedge sys_clk);
    or_test();
    xor_test();
    and_test();
    bfi_test();
    b2b_test();
    plain_test();
    report_and_stop();
  end
endmodule : decorated_store_rmw_tb
